// ===== include/panel_pkg.sv
// constants shared by the front-panel motion control block
package panel_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned HOLD_MS       = 2000;
  localparam int unsigned HOLD_CYC      = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_MS      = 100;
  localparam int unsigned FLASH_CYC     = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_COUNT   = 5;
  localparam int unsigned POS_W         = 32;
  localparam int unsigned VEL_W         = 16;
  localparam int unsigned SLIDER_W      = 8;
  localparam int unsigned STEPS         = 4;
  localparam int unsigned STEP_VEL_RST  = 16;

  // register word offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] REG_TARGET0   = 8'h10;
  localparam logic [7:0] REG_TARGET1   = 8'h14;
  localparam logic [7:0] REG_JOG_STEP  = 8'h18;
  localparam logic [7:0] REG_JOG_VEL   = 8'h1c;
  localparam logic [7:0] REG_DEAD      = 8'h20;
  localparam logic [7:0] REG_VEL_BASE  = 8'h24;

  // control register fields
  localparam int unsigned CTRL_MODE    = 0;
  localparam int unsigned CTRL_LED_LIM = 1;
  localparam int unsigned CTRL_LED_MOV = 2;
  localparam int unsigned CTRL_IDENT   = 3;

  // interrupt event bits
  localparam int unsigned EV_HOMED     = 0;
  localparam int unsigned EV_TAUGHT    = 1;
  localparam int unsigned EV_MODE      = 2;
  localparam int unsigned EV_LIMIT     = 3;
  localparam int unsigned EV_W         = 4;

  localparam logic [31:0] DEAD_RST     = 32'h0000_0008;
  localparam logic [31:0] JOG_STEP_RST = 32'h0000_0100;
  localparam logic [31:0] JOG_VEL_RST  = 32'h0000_0040;
  localparam logic [31:0] IDLE_DATA    = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_HOMING, ST_MOVE, ST_HELD
  } panel_state_t;
endpackage

// ===== hw/led_flasher.sv
`timescale 1ns/1ps
// activity led flasher: bursts of a fixed count, or continuous blinking
module led_flasher
  import panel_pkg::*;
#(
  parameter int unsigned HALF_CYC = FLASH_CYC,
  parameter int unsigned BURST    = FLASH_COUNT
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic burst_i,
  input  wire logic blink_i,
  input  wire logic solid_i,
  output logic      led_o,
  output logic      busy_o
);
  logic [31:0] tick_r;
  logic [3:0]  left_r;
  logic        phase_r;
  logic        blink_act_r;
  wire         tick_end = (tick_r == 32'(HALF_CYC - 1));
  wire         running  = (left_r != 4'h0) || blink_act_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r      <= 32'h0;
      left_r      <= 4'h0;
      phase_r     <= 1'b0;
      blink_act_r <= 1'b0;
    end else if (ce_i) begin
      blink_act_r <= blink_i;
      if (burst_i) begin
        // a new burst restarts the count so BURST flashes are seen while solid_i is low
        left_r  <= 4'(BURST);
        tick_r  <= 32'h0;
        phase_r <= 1'b1;
      end else if (running) begin
        tick_r <= tick_end ? 32'h0 : tick_r + 32'h1;
        if (tick_end) begin
          phase_r <= ~phase_r;
          if (phase_r && left_r != 4'h0)
            left_r <= left_r - 4'h1;
        end
      end else begin
        phase_r <= 1'b0;
        tick_r  <= 32'h0;
      end
    end
  end

  assign led_o  = solid_i | phase_r;
  assign busy_o = (left_r != 4'h0);
endmodule

// ===== hw/panel_motion.sv
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// front-panel motion control: slider, two buttons, homing, teach, led
// Behaviour
// RULE1: slider at centre commands zero velocity.
// RULE2: off-centre slider drives toward deflection, speed rising in configured steps.
// RULE3: both buttons held two seconds starts homing.
// RULE4: homing drives to home switch, then clears position counter.
// RULE5: either button press stops a homing or position move.
// RULE6: taught-position mode: press moves to that button's stored target.
// RULE7: taught-position mode: single button held two seconds stores current position.
// RULE8: after storing a target, led flashes five times.
// RULE9: jog mode: each press moves one increment, one button per direction.
// RULE10: mode setting selects jog or recall; jog uses stored jog parameters.
// RULE11: button held with slider up selects taught-position mode.
// RULE12: button held with slider down selects jog mode.
// RULE13: each panel mode change flashes led five times.
// RULE14: optionally led flashes on limit switches or host identify.
// RULE15: optionally led stays lit while motor moves.
// RULE16: two-button hold homes and never triggers a teach.
module panel_motion
  import panel_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned FLASH_HALF  = FLASH_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic [7:0]                 adr_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  input  wire logic                       we_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  output logic                            ack_o,
  output logic                            irq_o,
  input  wire logic signed [SLIDER_W-1:0] slider_i,
  input  wire logic                       btn_fwd_i,
  input  wire logic                       btn_rev_i,
  input  wire logic                       home_sw_i,
  input  wire logic                       lim_fwd_i,
  input  wire logic                       lim_rev_i,
  input  wire logic                       moving_i,
  input  wire logic                       move_done_i,
  input  wire logic [POS_W-1:0]           position_i,
  output logic signed [VEL_W-1:0]         vel_cmd_o,
  output logic                            vel_mode_o,
  output logic [POS_W-1:0]                target_o,
  output logic [VEL_W-1:0]                move_vel_o,
  output logic                            move_start_o,
  output logic                            move_rel_o,
  output logic                            move_stop_o,
  output logic                            pos_clear_o,
  output logic                            led_o
);
  panel_state_t state_r;
  logic [31:0]  ctrl_r;
  logic [31:0]  target_r [2];
  logic [31:0]  jog_step_r;
  logic [31:0]  jog_vel_r;
  logic [31:0]  dead_r;
  logic [VEL_W-1:0] step_vel_r [STEPS];
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic [31:0]  hold_r;
  logic         hold_fired_r;
  logic         both_seen_r;
  logic         btn_fwd_r;
  logic         btn_rev_r;
  logic         lim_r;
  logic [31:0]  dat_r;
  logic         ack_r;
  logic         ident_pulse;
  logic         flash_busy;

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = s[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  // bus decode
  wire bus_req = cyc_i & stb_i & ~ack_r;
  wire bus_wr  = bus_req & we_i & ce_i;
  wire wr_ctrl = bus_wr && adr_i == REG_CTRL;
  wire wr_stat = bus_wr && adr_i == REG_IRQ_STAT;
  wire wr_mask = bus_wr && adr_i == REG_IRQ_MASK;
  wire wr_t0   = bus_wr && adr_i == REG_TARGET0;
  wire wr_t1   = bus_wr && adr_i == REG_TARGET1;
  wire wr_jst  = bus_wr && adr_i == REG_JOG_STEP;
  wire wr_jvl  = bus_wr && adr_i == REG_JOG_VEL;
  wire wr_dead = bus_wr && adr_i == REG_DEAD;

  // slider decode
  wire signed [SLIDER_W-1:0] dead_s = SLIDER_W'(dead_r[SLIDER_W-1:0]);
  wire                 slider_up   = slider_i >  dead_s;
  wire                 slider_dn   = slider_i < -dead_s;
  wire                 slider_ctr  = ~slider_up & ~slider_dn;
  wire [SLIDER_W-1:0]  slider_mag  = slider_i[SLIDER_W-1] ? SLIDER_W'(-slider_i)
                                                          : SLIDER_W'(slider_i);
  wire [1:0]           step_idx    = slider_mag[SLIDER_W-2 -: 2];
  wire [VEL_W-1:0]     step_vel    = step_vel_r[step_idx];

  // button decode
  wire any_btn    = btn_fwd_i | btn_rev_i;
  wire both_btn   = btn_fwd_i & btn_rev_i;
  wire press_fwd  = btn_fwd_i & ~btn_fwd_r;
  wire press_rev  = btn_rev_i & ~btn_rev_r;
  wire any_press  = press_fwd | press_rev;
  wire release_ev = ~any_btn & (btn_fwd_r | btn_rev_r);
  wire hold_done  = (hold_r == 32'(HOLD_CYCLES - 1)) & ~hold_fired_r;
  wire mode_go    = ctrl_r[CTRL_MODE];
  wire in_move    = (state_r == ST_HOMING) || (state_r == ST_MOVE);
  wire sel_rev    = btn_rev_r & ~btn_fwd_r;

  wire do_home    = (state_r == ST_WAIT) & hold_done & both_btn;                  // [RULE3]
  wire do_teach   = (state_r == ST_WAIT) & hold_done & ~both_btn & ~both_seen_r
                    & mode_go & slider_ctr;                                       // [RULE7] [RULE16]
  wire to_go      = (state_r == ST_WAIT) & any_btn & slider_up & ~mode_go;        // [RULE11]
  wire to_jog     = (state_r == ST_WAIT) & any_btn & slider_dn & mode_go;         // [RULE12]
  wire mode_chg   = to_go | to_jog;
  wire short_rel  = (state_r == ST_WAIT) & release_ev & ~hold_fired_r
                    & ~both_seen_r;
  wire do_recall  = short_rel & mode_go;                                          // [RULE6]
  wire do_jog     = short_rel & ~mode_go;                                         // [RULE9]
  wire stop_req   = in_move & any_press;                                          // [RULE5]
  wire home_hit   = (state_r == ST_HOMING) & home_sw_i;
  wire lim_now    = lim_fwd_i | lim_rev_i;
  wire lim_ev     = lim_now & ~lim_r;

  wire [EV_W-1:0] events = {lim_ev, mode_chg, do_teach, home_hit};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_fwd_r    <= 1'b0;
      btn_rev_r    <= 1'b0;
      lim_r        <= 1'b0;
      hold_r       <= 32'h0;
      hold_fired_r <= 1'b0;
      both_seen_r  <= 1'b0;
    end else if (ce_i) begin
      btn_fwd_r <= btn_fwd_i;
      btn_rev_r <= btn_rev_i;
      lim_r     <= lim_now;
      // only one long-hold action may fire per press
      if (!any_btn || in_move) begin
        hold_r       <= 32'h0;
        hold_fired_r <= 1'b0;
        both_seen_r  <= 1'b0;
      end else begin
        if (!hold_fired_r)
          hold_r <= hold_done ? hold_r : hold_r + 32'h1;
        if (hold_done || mode_chg)
          hold_fired_r <= 1'b1;
        if (both_btn)
          both_seen_r <= 1'b1;                                                    // [RULE16]
      end
    end
  end

  // panel sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_r <= ST_IDLE;
    else if (ce_i) begin
      case (state_r)
        ST_IDLE:   if (any_press && !moving_i) state_r <= ST_WAIT;
        ST_WAIT:   if (do_home)                   state_r <= ST_HOMING;
                   else if (do_recall || do_jog)  state_r <= ST_MOVE;
                   else if (!any_btn)             state_r <= ST_IDLE;
        ST_HOMING: if (stop_req || home_hit)      state_r <= ST_HELD;             // [RULE4]
        ST_MOVE:   if (stop_req || move_done_i)   state_r <= ST_HELD;
        ST_HELD:   if (!any_btn)                  state_r <= ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r      <= 32'h0;
      target_r[0] <= 32'h0;
      target_r[1] <= 32'h0;
      jog_step_r  <= JOG_STEP_RST;
      jog_vel_r   <= JOG_VEL_RST;
      dead_r      <= DEAD_RST;
      irq_stat_r  <= '0;
      irq_mask_r  <= '0;
    end else if (ce_i) begin
      if (wr_ctrl)
        ctrl_r <= wmask(ctrl_r, dat_i, sel_i);
      else if (to_go)
        ctrl_r[CTRL_MODE] <= 1'b1;                                                // [RULE11]
      else if (to_jog)
        ctrl_r[CTRL_MODE] <= 1'b0;                                                // [RULE12]
      if (wr_ctrl && dat_i[CTRL_IDENT] && sel_i[0])
        ctrl_r[CTRL_IDENT] <= 1'b0;
      if (do_teach)
        target_r[sel_rev] <= position_i;                                          // [RULE7]
      else if (wr_t0)
        target_r[0] <= wmask(target_r[0], dat_i, sel_i);
      else if (wr_t1)
        target_r[1] <= wmask(target_r[1], dat_i, sel_i);
      if (wr_jst) jog_step_r <= wmask(jog_step_r, dat_i, sel_i);
      if (wr_jvl) jog_vel_r  <= wmask(jog_vel_r, dat_i, sel_i);
      if (wr_dead) dead_r    <= wmask(dead_r, dat_i, sel_i);
      if (wr_mask) irq_mask_r <= dat_i[EV_W-1:0];
      // a new event wins over a write-one clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? dat_i[EV_W-1:0] : '0)) | events;
    end
  end

  // speed table, one register per step
  genvar g;
  generate
    for (g = 0; g < STEPS; g++) begin : g_step
      wire wr_step = bus_wr && adr_i == 8'(REG_VEL_BASE + 8'(4 * g));
      always_ff @(posedge clk_i) begin
        if (rst_i)
          step_vel_r[g] <= VEL_W'((g + 1) * STEP_VEL_RST);
        else if (ce_i && wr_step)
          step_vel_r[g] <= dat_i[VEL_W-1:0];
      end
    end
  endgenerate

  // motion command outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vel_cmd_o    <= '0;
      vel_mode_o   <= 1'b0;
      target_o     <= '0;
      move_vel_o   <= '0;
      move_start_o <= 1'b0;
      move_rel_o   <= 1'b0;
      move_stop_o  <= 1'b0;
      pos_clear_o  <= 1'b0;
    end else if (ce_i) begin
      move_start_o <= 1'b0;
      move_stop_o  <= stop_req;                                                   // [RULE5]
      pos_clear_o  <= home_hit & ~stop_req;                                       // [RULE4]
      if (state_r == ST_HOMING && !home_hit) begin
        vel_mode_o <= 1'b1;
        vel_cmd_o  <= -$signed(VEL_W'(jog_vel_r[VEL_W-1:0]));                     // [RULE4]
      end else if (state_r == ST_IDLE && !any_btn && !slider_ctr) begin
        vel_mode_o <= 1'b1;
        vel_cmd_o  <= slider_up ? $signed(step_vel) : -$signed(step_vel);         // [RULE2]
      end else begin
        vel_mode_o <= (state_r == ST_IDLE) & slider_ctr;
        vel_cmd_o  <= '0;                                                         // [RULE1]
      end
      if (do_recall) begin
        move_start_o <= 1'b1;
        move_rel_o   <= 1'b0;
        target_o     <= target_r[sel_rev];                                        // [RULE6]
        move_vel_o   <= jog_vel_r[VEL_W-1:0];
      end else if (do_jog) begin
        move_start_o <= 1'b1;
        move_rel_o   <= 1'b1;
        target_o     <= sel_rev ? POS_W'(-jog_step_r) : jog_step_r;               // [RULE9]
        move_vel_o   <= jog_vel_r[VEL_W-1:0];                                     // [RULE10]
      end
    end
  end

  assign ident_pulse = wr_ctrl & dat_i[CTRL_IDENT] & sel_i[0];

  // teach and mode bursts always flash; limit and identify only when enabled
  wire flash_trig = do_teach | mode_chg // [RULE8] [RULE13]
                    | (ctrl_r[CTRL_LED_LIM] & (lim_ev | ident_pulse)); // [RULE14]

  led_flasher #(
    .HALF_CYC (FLASH_HALF),
    .BURST    (FLASH_COUNT)
  ) u_led (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .burst_i (flash_trig),
    .blink_i (1'b0),
    .solid_i (ctrl_r[CTRL_LED_MOV] & moving_i),                                   // [RULE15]
    .led_o   (led_o),
    .busy_o  (flash_busy)
  );

  // bus read mux and ack
  wire [31:0] rd_mux =
    adr_i == REG_CTRL     ? ctrl_r :
    adr_i == REG_STATUS   ? {26'h0, flash_busy, moving_i, 3'(state_r), mode_go} :
    adr_i == REG_IRQ_STAT ? 32'(irq_stat_r) :
    adr_i == REG_IRQ_MASK ? 32'(irq_mask_r) :
    adr_i == REG_TARGET0  ? target_r[0] :
    adr_i == REG_TARGET1  ? target_r[1] :
    adr_i == REG_JOG_STEP ? jog_step_r :
    adr_i == REG_JOG_VEL  ? jog_vel_r :
    adr_i == REG_DEAD     ? dead_r : IDLE_DATA;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= IDLE_DATA;
    end else if (ce_i) begin
      ack_r <= bus_req;
      if (bus_req && !we_i)
        dat_r <= rd_mux;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);

  chk_home_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    ce_i && do_home |=> state_r == ST_HOMING)
    else $error("homing did not start after two-button hold");
  chk_centre_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    ce_i && state_r == ST_IDLE && slider_ctr |=> vel_cmd_o == '0)
    else $error("centred slider gave non-zero velocity");
  chk_home_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    ce_i && home_hit && !stop_req |=> pos_clear_o && state_r == ST_HELD)
    else $error("home switch did not clear position");
  chk_stop_move: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    ce_i && in_move && any_press |=> move_stop_o && state_r == ST_HELD)
    else $error("button press did not stop move");
  chk_no_teach_both: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
    ce_i && (both_btn || both_seen_r) && !wr_t0 && !wr_t1
    |=> $stable(target_r[0]) && $stable(target_r[1]))
    else $error("target changed during two-button hold");
  chk_mode_up: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    ce_i && to_go && !wr_ctrl |=> mode_go)
    else $error("slider up did not select recall mode");
  chk_mode_down: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    ce_i && to_jog && !wr_ctrl |=> !mode_go)
    else $error("slider down did not select jog mode");
  chk_flash_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8] [RULE13]
    ce_i && (mode_chg || do_teach) |=> flash_busy)
    else $error("led burst not started");
  chk_moving_led: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
    ctrl_r[CTRL_LED_MOV] && moving_i |-> led_o)
    else $error("led dark while moving");
endmodule

// ===== tb/motion_partner.sv
// behavioural motion profiler and position counter facing the panel block
`timescale 1ns/1ps
module motion_partner (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  dur_i,
  input  wire logic        start_i,
  input  wire logic        rel_i,
  input  wire logic [31:0] target_i,
  input  wire logic        stop_i,
  input  wire logic        clear_i,
  input  wire logic        vmode_i,
  input  wire logic [15:0] vel_i,
  output logic             moving_o,
  output logic             done_o,
  output logic [31:0]      pos_o,
  output logic             home_o,
  output logic             lim_fwd_o,
  output logic             lim_rev_o
);
  logic signed [31:0] goal_r;
  logic [7:0]         cnt_r;
  // switches decode straight from the counter, so no debounce helps the panel
  assign home_o    = $signed(pos_o) <= 0;
  assign lim_fwd_o = $signed(pos_o) >= 32'sh0010_0000;
  assign lim_rev_o = $signed(pos_o) <= -32'sh0010_0000;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      pos_o    <= 32'h0000_0040;
      moving_o <= 1'b0;
    end else if (clear_i) begin
      pos_o <= 32'h0000_0000;
    end else if (stop_i) begin
      moving_o <= 1'b0;
    end else if (start_i) begin
      goal_r   <= rel_i ? $signed(pos_o) + $signed(target_i) : $signed(target_i);
      cnt_r    <= dur_i;
      moving_o <= 1'b1;
    end else if (moving_o) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h00) begin
        pos_o    <= goal_r;
        moving_o <= 1'b0;
        done_o   <= 1'b1;
      end
    end else if (vmode_i) begin
      pos_o <= pos_o + {{16{vel_i[15]}}, vel_i};
    end
  end
endmodule

// ===== tb/test_front_panel_motion_control.sv
// self-checking bench for the front-panel motion block against a profiler model
`timescale 1ns/1ps
module test_front_panel_motion_control;
  import panel_pkg::*;
  localparam int HOLD = 20;
  localparam int HALF = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic btn_fwd = 1'b0, btn_rev = 1'b0;
  logic [7:0]                 adr = 8'h00, dur = 8'h06;
  logic [31:0]                wdat = 32'h0, dat_o, target_o, position, q;
  logic signed [SLIDER_W-1:0] slider = '0;
  logic signed [VEL_W-1:0]    vel_cmd_o;
  logic [VEL_W-1:0]           move_vel_o;
  logic ack_o, irq_o, vel_mode_o, move_start_o, move_rel_o, move_stop_o, pos_clear_o, led_o;
  logic home_sw, lim_fwd, lim_rev, moving, move_done;
  int num_errors = 0, checks = 0;
  int tgt[2], step, jvel, n, m;
  always #4 clk_i = ~clk_i;
  panel_motion #(.HOLD_CYCLES(HOLD), .FLASH_HALF(HALF)) panel_motion_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .adr_i(adr), .dat_i(wdat), .dat_o(dat_o),
    .we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .irq_o(irq_o),
    .slider_i(slider), .btn_fwd_i(btn_fwd), .btn_rev_i(btn_rev), .home_sw_i(home_sw),
    .lim_fwd_i(lim_fwd), .lim_rev_i(lim_rev), .moving_i(moving), .move_done_i(move_done),
    .position_i(position), .vel_cmd_o(vel_cmd_o), .vel_mode_o(vel_mode_o),
    .target_o(target_o), .move_vel_o(move_vel_o), .move_start_o(move_start_o),
    .move_rel_o(move_rel_o), .move_stop_o(move_stop_o), .pos_clear_o(pos_clear_o),
    .led_o(led_o));
  motion_partner motion_partner_i (
    .clk_i(clk_i), .rst_i(rst_i), .dur_i(dur), .start_i(move_start_o), .rel_i(move_rel_o),
    .target_i(target_o), .stop_i(move_stop_o), .clear_i(pos_clear_o), .vmode_i(vel_mode_o),
    .vel_i(vel_cmd_o), .moving_o(moving), .done_o(move_done), .pos_o(position),
    .home_o(home_sw), .lim_fwd_o(lim_fwd), .lim_rev_o(lim_rev));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    adr  <= a;
    we   <= w;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 40);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (k >= 40) chk("ack", 0, 1);
  endtask
  task automatic press(input logic f, input logic r, input int c);
    @(posedge clk_i);
    btn_fwd <= f;
    btn_rev <= r;
    repeat (c) @(posedge clk_i);
    btn_fwd <= 1'b0;
    btn_rev <= 1'b0;
  endtask
  // waits on one event kind, bounded so a silent design cannot hang the run
  task automatic await(input int s, input int lim);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < lim && !hit; k++) begin
      @(negedge clk_i);
      case (s)
        0: hit = (move_start_o === 1'b1);
        1: hit = (move_stop_o === 1'b1);
        2: hit = (pos_clear_o === 1'b1);
        3: hit = (vel_cmd_o[VEL_W-1] === 1'b1);
        default: hit = (move_done === 1'b1);
      endcase
    end
    chk("await", hit, 1'b1);
  endtask
  task automatic leds(input int c);
    logic prev;
    prev = led_o;
    n = 0;
    repeat (c) begin
      @(negedge clk_i);
      if (led_o === 1'b1 && prev !== 1'b1) n++;
      prev = led_o;
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    test_done;
  end
  initial begin
    void'($urandom(52800));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(REG_JOG_STEP, 0, 0);
    chk("jog_step", q, JOG_STEP_RST);
    wb(REG_JOG_VEL, 0, 0);
    chk("jog_vel", q, JOG_VEL_RST);
    wb(REG_DEAD, 0, 0);
    chk("dead", q, DEAD_RST);
    wb(8'h40, 1, 32'hffff_ffff);
    wb(8'h40, 0, 0);
    chk("unmapped", q, IDLE_DATA);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      m = 16 + 32 * (i / 2) + $urandom_range(15);
      @(posedge clk_i);
      slider <= SLIDER_W'(i[0] ? -m : m);
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk("vel_mode", vel_mode_o, 1);
      chk("vel", vel_cmd_o, i[0] ? -16 * (i / 2 + 1) : 16 * (i / 2 + 1));
    end
    m = $urandom_range(16'h7ff, 16'h100);
    wb(REG_VEL_BASE + 8'hc, 1, m);
    repeat (2) @(negedge clk_i);
    chk("vel_table", vel_cmd_o, -m);
    @(posedge clk_i);
    slider <= '0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk("vel_zero", vel_cmd_o, 0);
    $display("test slider done");
    step = $urandom_range(16'hffff, 1);
    jvel = $urandom_range(8'hff, 8'h20);
    wb(REG_JOG_STEP, 1, step);
    wb(REG_JOG_VEL, 1, jvel);
    wb(REG_CTRL, 1, 32'h4);
    for (int i = 0; i < 2; i++) begin
      press(i == 0, i == 1, 3);
      await(0, 20);
      chk("rel", move_rel_o, 1);
      chk("step", target_o, i ? -step : step);
      chk("jvel", move_vel_o, jvel);
      repeat (3) @(negedge clk_i);
      chk("led_moving", led_o, 1);
      await(4, 40);
      repeat (3) @(negedge clk_i);
      chk("led_idle", led_o, 0);
    end
    $display("test jog done");
    wb(REG_CTRL, 1, 32'h1);
    for (int i = 0; i < 2; i++) begin
      tgt[i] = $urandom_range(16'hffff, 16'h100);
      wb(i ? REG_TARGET1 : REG_TARGET0, 1, tgt[i]);
    end
    dur <= 8'hc8;
    for (int i = 0; i < 2; i++) begin
      press(i == 0, i == 1, 3);
      await(0, 20);
      chk("abs", move_rel_o, 0);
      chk("goal", target_o, tgt[i]);
      fork
        press(i == 1, i == 0, 2);
        await(1, 20);
      join
    end
    dur <= 8'h02;
    $display("test recall done");
    fork
      press(1, 0, HOLD + 4);
      leds(HOLD + 100);
    join
    chk("teach_flashes", n, FLASH_COUNT);
    tgt[0] = position;
    wb(REG_TARGET0, 0, 0);
    chk("taught", q, tgt[0]);
    wb(REG_IRQ_MASK, 1, 32'h2);
    @(negedge clk_i);
    chk("irq", irq_o, 1);
    wb(REG_IRQ_STAT, 1, 32'h2);
    @(negedge clk_i);
    chk("irq_clr", irq_o, 0);
    $display("test teach done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      slider <= i ? 8'sh40 : -8'sh40;
      fork
        press(0, 1, 10);
        leds(HOLD + 100);
      join
      @(posedge clk_i);
      slider <= '0;
      repeat (20) @(posedge clk_i);
      wb(REG_CTRL, 0, 0);
      chk("mode", q[CTRL_MODE], i);
      chk("mode_flashes", n, FLASH_COUNT);
    end
    $display("test mode done");
    press(0, 1, 3);
    await(4, 40);
    // let the sequencer settle back to idle before the two-button hold
    repeat (3) @(posedge clk_i);
    fork
      press(1, 1, HOLD + 4);
      await(3, HOLD + 30);
    join
    await(2, 5000);
    wb(REG_TARGET0, 0, 0);
    chk("no_teach", q, tgt[0]);
    wb(REG_IRQ_STAT, 0, 0);
    chk("homed", q[EV_HOMED], 1);
    $display("test homing done");
    wb(REG_CTRL, 1, 32'h2);
    wb(REG_CTRL, 1, 32'ha);
    leds(16 * HALF);
    chk("ident", n, FLASH_COUNT - 1);
    $display("test ident done");
    test_done;
  end
endmodule
